// >>> rctx_defs.vh
// Constants for the reader command and transmit sequencer.
// Function
// - Power-up init starts automatically after reset.
// - Power-up init completion enters idle automatically.
// - During power-up init only page register readable.
// - Host commands cannot abort power-up init.
// - Command self-completion enters idle, sets idle flag.
// - Host idle aborts command without idle flag.
// - Host idle abort leaves FIFO untouched.
// - Transmit sends FIFO bytes, host started only.
// - Transmit with empty FIFO waits armed.
// - Empty FIFO at byte request ends transmit.
// - Transmission end sets transmit done flag.
// - Overwritten transmit code stops next cycle.
// - Frame is SOF, data, EOF; phase visible.
// - Optional CRC appended; parity per settings.
// - Last-bits sends partial byte, no parity.
// - Last-bits field clears after transmission.
// - Accept-more-data high appends bytes, low ends.
// - Accept-more-data checked one bit before last.
`ifndef RCTX_DEFS_VH
`define RCTX_DEFS_VH
`define RCTX_CMD_IDLE      6'h00
`define RCTX_CMD_TRANSMIT  6'h1a
`define RCTX_CMD_POWER_UP_INIT_COMMAND   6'h3f
`define RCTX_A_PAGE        8'h00
`define RCTX_A_COMMAND     8'h04
`define RCTX_A_FIFO        8'h08
`define RCTX_A_STATUS      8'h0c
`define RCTX_A_REDUND      8'h10
`define RCTX_A_FRAMING     8'h14
`define RCTX_A_FLAGS       8'h18
`define RCTX_F_PAR_EN      0
`define RCTX_F_PAR_ODD     1
`define RCTX_F_CRC_EN      2
`define RCTX_F_IDLE_FLAG   0
`define RCTX_F_TX_FLAG     1
`define RCTX_PH_IDLE       3'h0
`define RCTX_PH_WAIT       3'h1
`define RCTX_PH_SOF        3'h2
`define RCTX_PH_DATA       3'h3
`define RCTX_PH_EOF        3'h4
`define RCTX_CRC_PRESET    16'h6363
`define RCTX_CRC_POLY      16'h8408
`define RCTX_PAGE_RESET    8'h00
`define RCTX_BYTE_BITS     4'h8
`define RCTX_PAR_BITS      4'h9
`endif

// >>> rctx_sequencer.v
// Command state machine with the transmit sequencer and its APB register file.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "rctx_defs.vh"
module rctx_sequencer #(
    parameter INIT_CYCLES = 64,
    parameter BIT_DIV     = 16,
    parameter FIFO_DEPTH  = 64,
    parameter FIFO_AW     = 6
) (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        reset_powerdown_pin_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg         tx_bit_o,
    output reg         tx_active_o,
    output reg  [2:0]  modem_phase_o
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser; a falling edge restarts power-up init.
reg [2:0] pin_sync;
reg       pin_state;
always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        pin_sync  <= 3'h7;
        pin_state <= 1'b1;
    end else begin
        pin_sync <= {pin_sync[1:0], reset_powerdown_pin_i};
        if (pin_sync[1] == pin_sync[2])
            pin_state <= pin_sync[2];
    end
end
wire pin_fall = pin_state & (pin_sync[1] == pin_sync[2]) & ~pin_sync[2];

////////////////////////////////////////////////////////////////////////////////
// Bit clock enable.
reg [15:0] div_cnt;
wire       bit_tick = (div_cnt == BIT_DIV - 1);
always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
        div_cnt <= 16'h0000;
    else if (bit_tick)
        div_cnt <= 16'h0000;
    else
        div_cnt <= div_cnt + 16'h0001;
end

////////////////////////////////////////////////////////////////////////////////
// Registers and the APB slave.
reg  [5:0]  command;
reg  [7:0]  page;
reg  [2:0]  redundancy_config;
reg  [2:0]  transmit_last_bits;
reg         idle_interrupt_flag;
reg         transmit_done_flag;
reg  [15:0] init_cnt;
wire        starting = (command == `RCTX_CMD_POWER_UP_INIT_COMMAND);
wire        apb_acc  = psel_i & penable_i & pready_o;
wire        wr       = apb_acc & pwrite_i & ~starting;
wire        wr_cmd   = wr & (paddr_i == `RCTX_A_COMMAND);
wire        wr_fifo  = wr & (paddr_i == `RCTX_A_FIFO);
wire        rd_fifo  = apb_acc & ~pwrite_i & ~starting & (paddr_i == `RCTX_A_FIFO);

// Frame engine state, declared early for status read back.
localparam S_IDLE = 3'h0;
localparam S_WAIT = 3'h1;
localparam S_SOF  = 3'h2;
localparam S_DATA = 3'h3;
localparam S_CRC  = 3'h4;
localparam S_EOF  = 3'h5;
reg  [2:0]  state;
reg  [3:0]  bit_idx;
reg  [3:0]  bit_end;
reg  [7:0]  shreg;
reg         accept_more;
reg  [15:0] crc;
reg         crc_half;
reg         par_bit;
reg         tx_end;
reg         self_end;

// FIFO.
reg  [7:0]        fifo_mem [0:FIFO_DEPTH-1];
reg  [FIFO_AW:0]  wp;
reg  [FIFO_AW:0]  rp;
wire              fifo_empty = (wp == rp);
wire              fifo_full  = (wp[FIFO_AW-1:0] == rp[FIFO_AW-1:0]) &
                               (wp[FIFO_AW] != rp[FIFO_AW]);
reg               pop;

always @(posedge clk_i) begin
    if (wr_fifo & ~fifo_full)
        fifo_mem[wp[FIFO_AW-1:0]] <= pwdata_i[7:0];
end

always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        wp <= {(FIFO_AW+1){1'b0}};
        rp <= {(FIFO_AW+1){1'b0}};
    end else begin
        if (wr_fifo & ~fifo_full)
            wp <= wp + 1'b1;
        if ((pop | rd_fifo) & ~fifo_empty)
            rp <= rp + 1'b1;
    end
end

function [31:0] rd_mux;
    input [7:0] a;
    begin
        case (a)
            `RCTX_A_PAGE:    rd_mux = {24'h000000, page};
            `RCTX_A_COMMAND: rd_mux = {26'h0000000, command};
            `RCTX_A_FIFO:    rd_mux = {24'h000000, fifo_mem[rp[FIFO_AW-1:0]]};
            `RCTX_A_STATUS:  rd_mux = {23'h000000, fifo_full, fifo_empty,
                                       accept_more, 3'h0, modem_phase_o};
            `RCTX_A_REDUND:  rd_mux = {29'h00000000, redundancy_config};
            `RCTX_A_FRAMING: rd_mux = {29'h00000000, transmit_last_bits};
            `RCTX_A_FLAGS:   rd_mux = {30'h00000000, transmit_done_flag,
                                       idle_interrupt_flag};
            default:         rd_mux = 32'h00000000;
        endcase
    end
endfunction

function mapped;
    input [7:0] a;
    begin
        mapped = (a <= `RCTX_A_FLAGS) & (a[1:0] == 2'h0);
    end
endfunction

// No wait state: pready rises in the first access cycle.
always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o  <= 32'h00000000;
    end else begin
        pready_o  <= psel_i & ~penable_i;
        pslverr_o <= psel_i & ~penable_i & ~mapped(paddr_i);
        // Read data is latched in the setup cycle so it stands for the whole access.
        if (psel_i & ~penable_i & ~pwrite_i) begin
            if (starting & (paddr_i != `RCTX_A_PAGE))
                prdata_o <= 32'h00000000;
            else
                prdata_o <= rd_mux(paddr_i);
        end
    end
end

always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        page              <= `RCTX_PAGE_RESET;
        redundancy_config <= 3'h0;
    end else if (wr) begin
        if (paddr_i == `RCTX_A_PAGE)
            page <= pwdata_i[7:0];
        if (paddr_i == `RCTX_A_REDUND)
            redundancy_config <= pwdata_i[2:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Command register, flags and last-bits field.
always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        command             <= `RCTX_CMD_POWER_UP_INIT_COMMAND;
        init_cnt            <= 16'h0000;
        idle_interrupt_flag <= 1'b0;
        transmit_done_flag  <= 1'b0;
        transmit_last_bits  <= 3'h0;
    end else begin
        if (pin_fall) begin
            command  <= `RCTX_CMD_POWER_UP_INIT_COMMAND;
            init_cnt <= 16'h0000;
        end else if (starting) begin
            if (init_cnt == INIT_CYCLES - 1) begin
                command <= `RCTX_CMD_IDLE;
                idle_interrupt_flag <= 1'b1;
            end else
                init_cnt <= init_cnt + 16'h0001;
        end else if (wr_cmd & (pwdata_i[5:0] != `RCTX_CMD_POWER_UP_INIT_COMMAND))
            command <= pwdata_i[5:0];
        else if (self_end) begin
            command <= `RCTX_CMD_IDLE;
            idle_interrupt_flag <= 1'b1;
        end
        if (tx_end)
            transmit_done_flag <= 1'b1;
        else if (wr & (paddr_i == `RCTX_A_FLAGS) & pwdata_i[`RCTX_F_TX_FLAG])
            transmit_done_flag <= 1'b0;
        if (wr & (paddr_i == `RCTX_A_FLAGS) & pwdata_i[`RCTX_F_IDLE_FLAG] &
            ~(starting & (init_cnt == INIT_CYCLES - 1)) & ~self_end)
            idle_interrupt_flag <= 1'b0;
        if (tx_end)
            transmit_last_bits <= 3'h0;
        else if (wr & (paddr_i == `RCTX_A_FRAMING))
            transmit_last_bits <= pwdata_i[2:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frame engine.
wire par_en  = redundancy_config[`RCTX_F_PAR_EN];
wire par_odd = redundancy_config[`RCTX_F_PAR_ODD];
wire crc_en  = redundancy_config[`RCTX_F_CRC_EN];
wire tx_cmd  = (command == `RCTX_CMD_TRANSMIT);

// Bits of one byte on the air; only the final byte may be trimmed.
function [3:0] byte_len;
    input       last;
    input [2:0] trim;
    input       with_par;
    begin
        if (last && trim != 3'h0)
            byte_len = {1'b0, trim};
        else if (with_par)
            byte_len = `RCTX_PAR_BITS;
        else
            byte_len = `RCTX_BYTE_BITS;
    end
endfunction

// Parity bit of a byte; even parity makes the count of ones even.
function par_of;
    input [7:0] b;
    input       odd;
    begin
        par_of = ^b ^ odd;
    end
endfunction

// One reflected CRC step for the bit being sent.
function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
        if (c[0] ^ b)
            crc_step = (c >> 1) ^ `RCTX_CRC_POLY;
        else
            crc_step = c >> 1;
    end
endfunction

// The head byte is the last one when nothing else waits behind it.
wire [7:0]  head_byte = fifo_mem[rp[FIFO_AW-1:0]];
wire        head_last = (rp + 1'b1 == wp);
wire [15:0] crc_next  = crc_step(crc, shreg[0]);

always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        state         <= S_IDLE;
        bit_idx       <= 4'h0;
        bit_end       <= `RCTX_BYTE_BITS;
        par_bit       <= 1'b0;
        shreg         <= 8'h00;
        accept_more   <= 1'b0;
        crc           <= `RCTX_CRC_PRESET;
        crc_half      <= 1'b0;
        tx_end        <= 1'b0;
        self_end      <= 1'b0;
        pop           <= 1'b0;
        tx_bit_o      <= 1'b0;
        tx_active_o   <= 1'b0;
        modem_phase_o <= `RCTX_PH_IDLE;
    end else begin
        tx_end   <= 1'b0;
        self_end <= 1'b0;
        pop      <= 1'b0;
        if (~tx_cmd | self_end) begin
            state       <= S_IDLE;
            tx_active_o <= 1'b0;
            tx_bit_o    <= 1'b0;
        end else case (state)
            S_IDLE: state <= S_WAIT;
            S_WAIT: if (~fifo_empty & bit_tick) begin
                state       <= S_SOF;
                accept_more <= 1'b1;
                crc         <= `RCTX_CRC_PRESET;
                tx_active_o <= 1'b1;
                tx_bit_o    <= 1'b1;
            end
            S_SOF: if (bit_tick) begin
                state   <= S_DATA;
                shreg   <= head_byte;
                par_bit <= par_of(head_byte, par_odd);
                pop     <= 1'b1;
                bit_idx <= 4'h0;
                bit_end <= byte_len(head_last, transmit_last_bits, par_en);
            end
            S_DATA: if (bit_tick) begin
                // Check one bit before the last expected bit.
                if (bit_idx + 4'h2 == bit_end)
                    accept_more <= ~fifo_empty;
                if (bit_idx < `RCTX_BYTE_BITS) begin
                    tx_bit_o <= shreg[0];
                    if (crc_en)
                        crc <= crc_next;
                    shreg    <= {1'b0, shreg[7:1]};
                end else
                    tx_bit_o <= par_bit;
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx + 4'h1 == bit_end) begin
                    // A trimmed byte always closes the frame, whatever the FIFO holds.
                    if (bit_end < `RCTX_BYTE_BITS)
                        state <= S_EOF;
                    else if (accept_more & ~fifo_empty) begin
                        shreg   <= head_byte;
                        par_bit <= par_of(head_byte, par_odd);
                        pop     <= 1'b1;
                        bit_idx <= 4'h0;
                        bit_end <= byte_len(head_last, transmit_last_bits, par_en);
                    end else if (crc_en) begin
                        state    <= S_CRC;
                        shreg    <= par_en ? crc[7:0] : crc_next[7:0];
                        par_bit  <= par_of(par_en ? crc[7:0] : crc_next[7:0], par_odd);
                        crc_half <= 1'b0;
                        bit_idx  <= 4'h0;
                    end else
                        state <= S_EOF;
                end
            end
            // CRC bytes follow the data under the same parity rule.
            S_CRC: if (bit_tick) begin
                tx_bit_o <= (bit_idx < `RCTX_BYTE_BITS) ? shreg[0] : par_bit;
                shreg    <= {1'b0, shreg[7:1]};
                bit_idx  <= bit_idx + 4'h1;
                if (bit_idx + 4'h1 == bit_end) begin
                    bit_idx  <= 4'h0;
                    crc_half <= 1'b1;
                    shreg    <= crc[15:8];
                    par_bit  <= par_of(crc[15:8], par_odd);
                    if (crc_half)
                        state <= S_EOF;
                end
            end
            S_EOF: if (bit_tick) begin
                tx_bit_o    <= 1'b0;
                tx_active_o <= 1'b0;
                accept_more <= 1'b0;
                tx_end      <= 1'b1;
                self_end    <= 1'b1;
                state       <= S_IDLE;
            end
            default: state <= S_IDLE;
        endcase
        // FIFO contents are never flushed on abort.
        case (state)
            S_WAIT:  modem_phase_o <= `RCTX_PH_WAIT;
            S_SOF:   modem_phase_o <= `RCTX_PH_SOF;
            S_DATA:  modem_phase_o <= `RCTX_PH_DATA;
            S_CRC:   modem_phase_o <= `RCTX_PH_DATA;
            S_EOF:   modem_phase_o <= `RCTX_PH_EOF;
            default: modem_phase_o <= `RCTX_PH_IDLE;
        endcase
        // An abort shows idle at once rather than a stale data phase.
        if (~tx_cmd | self_end)
            modem_phase_o <= `RCTX_PH_IDLE;
    end
end

endmodule // rctx_sequencer

// >>> rctx_sequencer_asserts.sv
// Port-level concurrent checks for the sequencer.
`timescale 1ns/1ns
module rctx_sequencer_asserts (
    input wire       clk_i,
    input wire       rstn_i,
    input wire       psel_i,
    input wire       penable_i,
    input wire       pready_o,
    input wire       pslverr_o,
    input wire       tx_active_o,
    input wire [2:0] modem_phase_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_quiet;
        (modem_phase_o == 3'h0) [*2];
    endsequence
    // The slave answers in the first access cycle, so no wait state.
    AST_ACCESS_READY: assert property (s_setup |=> pready_o && penable_i)
        else $error("pready missing in access cycle");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    AST_READY_IN_ACCESS: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside access");
    AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    AST_PHASE_RANGE: assert property (modem_phase_o <= 3'h4)
        else $error("phase code out of range");
    AST_DATA_ACTIVE: assert property (modem_phase_o == 3'h3 |-> tx_active_o)
        else $error("data phase while inactive");
    AST_QUIET_INACTIVE: assert property (s_quiet |-> !tx_active_o)
        else $error("active while phase idle");
    AST_SOF_LEADS: assert property ($rose(modem_phase_o == 3'h3)
        |-> $past(modem_phase_o) == 3'h2)
        else $error("data not preceded by start");
    AST_EOF_AFTER_DATA: assert property ($fell(modem_phase_o == 3'h3)
        |-> modem_phase_o inside {3'h0, 3'h4})
        else $error("data left to wrong phase");
endmodule // rctx_sequencer_asserts

// >>> rctx_host_model.sv
// APB master standing in for the host processor.
`timescale 1ns/1ns
module rctx_host_model (
    input  wire        clk_i,
    input  wire [31:0] prdata_i,
    input  wire        pready_i,
    input  wire        pslverr_i,
    output reg         psel_o = 1'b0,
    output reg         penable_o = 1'b0,
    output reg         pwrite_o = 1'b0,
    output reg  [7:0]  paddr_o = 8'h00,
    output reg  [31:0] pwdata_o = 32'h0
);
    // The request is held until pready is sampled high, then released.
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r, output e);
        begin
            @(posedge clk_i);
            psel_o <= 1'b1;
            penable_o <= 1'b0;
            pwrite_o <= w;
            paddr_o <= a;
            pwdata_o <= d;
            @(posedge clk_i);
            penable_o <= 1'b1;
            @(posedge clk_i);
            while (!pready_i) @(posedge clk_i);
            r = prdata_i;
            e = pslverr_i;
            psel_o <= 1'b0;
            penable_o <= 1'b0;
        end
    endtask
endmodule // rctx_host_model

// >>> rctx_sequencer_test.sv
// Self-checking bench for the command and transmit sequencer.
`timescale 1ns/1ns
`include "rctx_defs.vh"
module rctx_sequencer_test;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        pd_pin = 1'b1;
    wire         psel, penable, pwrite, pready, pslverr, tx_bit, tx_active;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata, prdata;
    wire  [2:0]  phase;
    int          n_fail = 0;
    int          checked = 0;
    int          k;
    logic [31:0] rd;
    logic        er;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} rctx_row_t;
    rctx_row_t   rows [4] = '{'{`RCTX_A_PAGE, 32'h5a, 32'h5a, 1'b0},
        '{`RCTX_A_REDUND, 32'h7, 32'h7, 1'b0}, '{`RCTX_A_FRAMING, 32'h3, 32'h3, 1'b0},
        '{8'h1c, 32'h5, 32'h0, 1'b1}};
    always #2 clk_i = ~clk_i;
    rctx_sequencer #(.INIT_CYCLES(8), .BIT_DIV(4)) u_rctx_sequencer (.clk_i(clk_i),
        .rstn_i(rstn_i), .reset_powerdown_pin_i(pd_pin), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_bit_o(tx_bit),
        .tx_active_o(tx_active), .modem_phase_o(phase));
    rctx_host_model u_rctx_host_model (.clk_i(clk_i), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    ////////////////////////////////////////////////////////////////////////
    task wr(input [7:0] a, input [31:0] d);
        u_rctx_host_model.xfer(1'b1, a, d, rd, er);
    endtask
    task rdr(input [7:0] a);
        u_rctx_host_model.xfer(1'b0, a, 32'h0, rd, er);
    endtask
    task cmp(input [31:0] g, input [31:0] x);
        checked++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask
    // Reads other than page return zero during start-up, so polling only helps once it is over.
    task poll;
        repeat (16) @(posedge clk_i);
        rdr(`RCTX_A_COMMAND);
        while (rd !== 32'h0) rdr(`RCTX_A_COMMAND);
    endtask
    task wait_tx(input logic lvl);
        k = 0;
        while (tx_active !== lvl && k < 500) begin
            @(posedge clk_i);
            k++;
        end
    endtask
    task print_verdict;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        wr(`RCTX_A_COMMAND, 32'h1a);
        rdr(`RCTX_A_STATUS);
        cmp(rd, 32'h0);
        poll;
        cmp(rd, 32'h0);
        rdr(`RCTX_A_FLAGS);
        cmp(32'(rd[0]), 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(rows[i].a, rows[i].d);
            rdr(rows[i].a);
            cmp(rd, rows[i].x);
            cmp(32'(er), 32'(rows[i].e));
        end
        wr(`RCTX_A_REDUND, 32'h1);
        wr(`RCTX_A_FLAGS, 32'h3);
        wr(`RCTX_A_COMMAND, 32'h1a);
        repeat (2) @(posedge clk_i);
        rdr(`RCTX_A_STATUS);
        cmp(32'(rd[2:0]), 32'h1);
        wr(`RCTX_A_FIFO, 32'ha5);
        wait_tx(1'b1);
        cmp(32'(tx_bit), 32'h1);
        wait_tx(1'b0);
        cmp(32'(tx_bit), 32'h0);
        rdr(`RCTX_A_COMMAND);
        cmp(rd, 32'h0);
        rdr(`RCTX_A_FLAGS);
        cmp(rd, 32'h3);
        rdr(`RCTX_A_FRAMING);
        cmp(rd, 32'h0);
        for (int i = 1; i < 4; i++) wr(`RCTX_A_FIFO, 32'(i * 17));
        wr(`RCTX_A_FLAGS, 32'h3);
        rdr(`RCTX_A_STATUS);
        cmp(32'(rd[2:0]), 32'h0);
        wr(`RCTX_A_COMMAND, 32'h1a);
        wait_tx(1'b1);
        wr(`RCTX_A_COMMAND, 32'h0);
        repeat (2) @(posedge clk_i);
        cmp(32'(tx_active), 32'h0);
        rdr(`RCTX_A_FLAGS);
        cmp(32'(rd[0]), 32'h0);
        rdr(`RCTX_A_STATUS);
        cmp(32'(rd[7]), 32'h0);
        wr(`RCTX_A_COMMAND, 32'h3f);
        rdr(`RCTX_A_COMMAND);
        cmp(rd, 32'h0);
        wr(`RCTX_A_FLAGS, 32'h3);
        pd_pin <= 1'b0;
        poll;
        rdr(`RCTX_A_FLAGS);
        cmp(32'(rd[0]), 32'h1);
        print_verdict;
    end
endmodule // rctx_sequencer_test
bind rctx_sequencer rctx_sequencer_asserts u_rctx_sequencer_asserts (.clk_i(clk_i),
    .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .tx_active_o(tx_active_o), .modem_phase_o(modem_phase_o));
